//--- pkg/tsi_pkg.sv
package tsi_pkg;

	// timing of the internal reference clock and the bus-stuck timeout
	localparam int unsigned REF_CLK_HZ  = 50_000_000;
	localparam int unsigned TIMEOUT_MS  = 30;
	localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * (REF_CLK_HZ / 1000);
	localparam int unsigned TOUT_W      = 21;

	// deglitch: a line level must stand this many samples to be taken
	localparam int unsigned FILT_CYC    = 2;

	// strap-time settling, in reference clocks after reset release
	localparam logic [1:0]  STRAP_SETTLE = 2'h3;

	// slave address layout: fixed top bits, middle pair from high strap
	localparam logic [2:0]  ADDR_TOP     = 3'h4;
	localparam logic [1:0]  ADDR_MID_SCL = 2'h1;
	localparam logic [1:0]  ADDR_MID_STD = 2'h2;
	localparam logic [6:0]  ADDR_RESET   = 7'h48;
	localparam logic [6:0]  START_BYTE   = 7'h00;
	localparam logic        DIR_READ     = 1'h1;

	// index pointer and register numbering
	localparam logic [7:0]  INDEX_RESET  = 8'h00;
	localparam logic [7:0]  TEMP_INDEX   = 8'h00;

	// bit counting within a byte
	localparam logic [3:0]  BITS_BYTE    = 4'h8;
	localparam logic [3:0]  LAST_TX_BIT  = 4'h7;
	localparam logic [3:0]  ACK_SEEN     = 4'h1;

	// what a strap pin is tied to, as classified by the pad
	typedef enum logic [1:0] {
		STRAP_GND = 2'b00,
		STRAP_VDD = 2'b01,
		STRAP_SDA = 2'b10,
		STRAP_SCL = 2'b11
	} tsi_strap_e;

	// serial port protocol states
	typedef enum logic [3:0] {
		ST_IDLE      = 4'b0000,
		ST_ADDR      = 4'b0001,
		ST_ADDR_ACK  = 4'b0010,
		ST_INDEX     = 4'b0011,
		ST_INDEX_ACK = 4'b0100,
		ST_WDATA     = 4'b0101,
		ST_WDATA_ACK = 4'b0110,
		ST_RDATA     = 4'b0111,
		ST_MACK      = 4'b1000
	} tsi_state_e;

	typedef logic [15:0] tsi_word_t;

	// one completed register write towards the sensor core
	typedef struct packed {
		logic       valid;
		logic [7:0] index;
		tsi_word_t  data;
	} tsi_wr_s;

endpackage : tsi_pkg

//--- design/tsi_sync_filt.sv
`timescale 1ns/1ns
`default_nettype none

module tsi_sync_filt #(
	parameter int unsigned FILT    = tsi_pkg::FILT_CYC,
	parameter logic        RST_VAL = 1'h1
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic pin,
	output var  logic filt_q
);

	logic       s1_q;
	logic       s2_q;
	logic [1:0] cnt_q;
	logic [1:0] cnt_d;
	logic       filt_d;

	// a new level is taken only after it stood FILT samples, so spikes
	// shorter than that never reach the start/stop detector
	always_comb begin
		filt_d = filt_q;
		cnt_d  = 2'h0;
		if (s2_q != filt_q) begin
			if (cnt_q == 2'(FILT - 1)) begin
				filt_d = s2_q;
			end else begin
				cnt_d = cnt_q + 2'h1;
			end
		end
	end

	// two-stage synchroniser, then the filter registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q   <= RST_VAL;
			s2_q   <= RST_VAL;
			cnt_q  <= 2'h0;
			filt_q <= RST_VAL;
		end else begin
			s1_q   <= pin;
			s2_q   <= s1_q;
			cnt_q  <= cnt_d;
			filt_q <= filt_d;
		end
	end

endmodule : tsi_sync_filt

`default_nettype wire

//--- design/tsi_bit_cap.sv
`timescale 1ns/1ns
`default_nettype none

module tsi_bit_cap (
	input  wire logic scl_clk,
	input  wire logic rst_n,
	input  wire logic sda_i,
	output var  logic bit_q,
	output var  logic tog_q
);

	logic bit_d;
	logic tog_d;

	// the bit is held until the next clock rise, which is far longer than
	// the toggle needs to cross, so the reader always sees it settled
	always_comb begin
		bit_d = sda_i;
		tog_d = ~tog_q;
	end

	// data is taken on the rising serial clock edge itself
	always_ff @(posedge scl_clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_q <= 1'h1;
			tog_q <= 1'h0;
		end else begin
			bit_q <= bit_d;
			tog_q <= tog_d;
		end
	end

endmodule : tsi_bit_cap

`default_nettype wire

//--- design/tsi_port.sv
// Behaviour
// - start: data falls with clock high
// - first byte: address plus direction bit
// - data bits sampled on clock rise
// - addressed device acks on ninth pulse
// - data change with clock high: start/stop
// - stop: data rises with clock high; idle
// - clock rates 1 kHz to 3.4 MHz
// - bytes move most significant bit first
// - address from two strap pins
// - reads use last written index pointer
// - index pointer kept across transfers
// - words move high byte then low byte
// - slave only, never drives clock line
// - ack address, index, store data bytes
// - start or stop ends a write
// - read sends high byte then low byte
// - nack, start or stop ends a read
// - temperature word two's complement, 1/128 C
// - index pointer resets to temperature register
// - clock low 30 ms resets port
// - read at address zero is acknowledged
`timescale 1ns/1ns
`default_nettype none

module tsi_port #(
	parameter int unsigned TIMEOUT_CYCLES = tsi_pkg::TIMEOUT_CYC
) (
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic              scl_clk,
	input  wire logic              sda_i,
	output var  logic              sda_o,
	output var  logic              sda_oe_n,
	output var  logic              scl_o,
	output var  logic              scl_oe_n,
	input  wire logic [1:0]        addr_strap_low,
	input  wire logic [1:0]        addr_strap_high,
	input  wire tsi_pkg::tsi_word_t temp_value_word,
	input  wire tsi_pkg::tsi_word_t reg_rd_data,
	output var  logic [7:0]        reg_index,
	output var  tsi_pkg::tsi_wr_s  reg_wr,
	output var  logic              busy
);

	// filtered line levels in the reference domain
	logic scl_f;
	logic sda_f;
	logic scl_f_q;
	logic sda_f_q;

	// bits captured in the serial clock domain
	logic cap_bit;
	logic cap_tog;
	logic tog_s1_q;
	logic tog_s2_q;
	logic tog_s3_q;

	// edge and condition pulses
	logic bit_evt;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic tout_hit;

	// strap capture
	logic [1:0] strap_lo_s1_q;
	logic [1:0] strap_lo_s2_q;
	logic [1:0] strap_hi_s1_q;
	logic [1:0] strap_hi_s2_q;
	logic [1:0] strap_cnt_q;
	logic [1:0] strap_cnt_d;
	logic [6:0] addr_q;
	logic [6:0] addr_d;

	// protocol state
	tsi_pkg::tsi_state_e state_q;
	tsi_pkg::tsi_state_e state_d;
	logic [3:0]          cnt_q;
	logic [3:0]          cnt_d;
	logic [7:0]          shift_q;
	logic [7:0]          shift_d;
	logic                rw_q;
	logic                rw_d;
	logic                hi_done_q;
	logic                hi_done_d;
	logic [7:0]          wr_hi_q;
	logic [7:0]          wr_hi_d;
	logic                nack_q;
	logic                nack_d;
	tsi_pkg::tsi_word_t  word_q;
	tsi_pkg::tsi_word_t  word_d;
	logic [7:0]          index_q;
	logic [7:0]          index_d;
	tsi_pkg::tsi_wr_s    wr_d;
	logic                oe_n_d;
	logic                busy_d;

	// timeout counter
	logic [tsi_pkg::TOUT_W-1:0] tout_q;
	logic [tsi_pkg::TOUT_W-1:0] tout_d;

	// both lines are cleaned before start, stop or clock-fall edges are looked at; the filter
	// adds a few cycles of delay, which still leaves room at 3.4 MHz
	tsi_sync_filt #(
		.FILT    (tsi_pkg::FILT_CYC),
		.RST_VAL (1'h1)
	) u_scl_filt (
		.clk    (ref_clk),
		.rst_n  (rst_n),
		.pin    (scl_clk),
		.filt_q (scl_f)
	);

	tsi_sync_filt #(
		.FILT    (tsi_pkg::FILT_CYC),
		.RST_VAL (1'h1)
	) u_sda_filt (
		.clk    (ref_clk),
		.rst_n  (rst_n),
		.pin    (sda_i),
		.filt_q (sda_f)
	);

	// the data bit itself is taken by the serial clock
	tsi_bit_cap u_bit_cap (
		.scl_clk (scl_clk),
		.rst_n   (rst_n),
		.sda_i   (sda_i),
		.bit_q   (cap_bit),
		.tog_q   (cap_tog)
	);

	// toggle crossing; s1 feeds only s2
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tog_s1_q <= 1'h0;
			tog_s2_q <= 1'h0;
			tog_s3_q <= 1'h0;
			scl_f_q  <= 1'h1;
			sda_f_q  <= 1'h1;
		end else begin
			tog_s1_q <= cap_tog;
			tog_s2_q <= tog_s1_q;
			tog_s3_q <= tog_s2_q;
			scl_f_q  <= scl_f;
			sda_f_q  <= sda_f;
		end
	end

	// any data change during clock high is a bus condition
	assign bit_evt   = tog_s2_q ^ tog_s3_q;
	assign scl_fall  = scl_f_q & ~scl_f;
	assign start_det = scl_f & scl_f_q & sda_f_q & ~sda_f;
	assign stop_det  = scl_f & scl_f_q & ~sda_f_q & sda_f;

	// straps pass two flops, then are caught during settling only
	always_comb begin
		strap_cnt_d = strap_cnt_q;
		addr_d      = addr_q;
		if (strap_cnt_q != tsi_pkg::STRAP_SETTLE) begin
			strap_cnt_d = strap_cnt_q + 2'h1;
			if (strap_hi_s2_q == tsi_pkg::STRAP_SCL) begin
				addr_d = {tsi_pkg::ADDR_TOP, tsi_pkg::ADDR_MID_SCL,
					strap_lo_s2_q};
			end else begin
				addr_d = {tsi_pkg::ADDR_TOP, tsi_pkg::ADDR_MID_STD,
					strap_lo_s2_q};
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_lo_s1_q <= 2'h0;
			strap_lo_s2_q <= 2'h0;
			strap_hi_s1_q <= 2'h0;
			strap_hi_s2_q <= 2'h0;
			strap_cnt_q   <= 2'h0;
			addr_q        <= tsi_pkg::ADDR_RESET;
		end else begin
			strap_lo_s1_q <= addr_strap_low;
			strap_lo_s2_q <= strap_lo_s1_q;
			strap_hi_s1_q <= addr_strap_high;
			strap_hi_s2_q <= strap_hi_s1_q;
			strap_cnt_q   <= strap_cnt_d;
			addr_q        <= addr_d;
		end
	end

	// a master that freezes the clock low mid-frame cannot hold the
	// data line forever; the count runs only while a frame is open
	always_comb begin
		tout_d = '0;
		if (!scl_f && state_q != tsi_pkg::ST_IDLE && !tout_hit) begin
			tout_d = tout_q + 1'h1;
		end
	end

	assign tout_hit = (tout_q == tsi_pkg::TOUT_W'(TIMEOUT_CYCLES));

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tout_q <= '0;
		end else begin
			tout_q <= tout_d;
		end
	end

	// protocol engine: receive on bit events, drive on clock falls
	always_comb begin
		state_d   = state_q;
		cnt_d     = cnt_q;
		shift_d   = shift_q;
		rw_d      = rw_q;
		hi_done_d = hi_done_q;
		wr_hi_d   = wr_hi_q;
		nack_d    = nack_q;
		word_d    = word_q;
		index_d   = index_q;
		wr_d      = reg_wr;
		wr_d.valid = 1'h0;
		oe_n_d    = sda_oe_n;

		if (bit_evt) begin
			shift_d = {shift_q[6:0], cap_bit};
		end

		if (tout_hit) begin
			state_d = tsi_pkg::ST_IDLE;
			oe_n_d  = 1'h1;
		end else if (start_det) begin
			// a restart ends any write or read in progress
			state_d = tsi_pkg::ST_ADDR;
			cnt_d   = 4'h0;
			oe_n_d  = 1'h1;
		end else if (stop_det) begin
			state_d = tsi_pkg::ST_IDLE;
			oe_n_d  = 1'h1;
		end else begin
			case (state_q)
				tsi_pkg::ST_IDLE: begin
					oe_n_d = 1'h1;
				end
				tsi_pkg::ST_ADDR, tsi_pkg::ST_INDEX,
				tsi_pkg::ST_WDATA: begin
					if (bit_evt) begin
						cnt_d = cnt_q + 4'h1;
					end
					if (scl_fall && cnt_q == tsi_pkg::BITS_BYTE) begin
						cnt_d  = 4'h0;
						oe_n_d = 1'h0;
						if (state_q == tsi_pkg::ST_ADDR) begin
							rw_d      = shift_q[0];
							hi_done_d = 1'h0;
							if (shift_q[7:1] == addr_q ||
								(shift_q[7:1] == tsi_pkg::START_BYTE &&
								shift_q[0] == tsi_pkg::DIR_READ)) begin
								state_d = tsi_pkg::ST_ADDR_ACK;
							end else begin
								state_d = tsi_pkg::ST_IDLE;
								oe_n_d  = 1'h1;
							end
						end else if (state_q == tsi_pkg::ST_INDEX) begin
							index_d = shift_q;
							state_d = tsi_pkg::ST_INDEX_ACK;
						end else begin
							state_d = tsi_pkg::ST_WDATA_ACK;
							if (!hi_done_q) begin
								wr_hi_d   = shift_q;
								hi_done_d = 1'h1;
							end else begin
								wr_d.valid = 1'h1;
								wr_d.index = index_q;
								wr_d.data  = {wr_hi_q, shift_q};
								hi_done_d  = 1'h0;
							end
						end
					end
				end
				tsi_pkg::ST_ADDR_ACK: begin
					if (scl_fall) begin
						if (rw_q == tsi_pkg::DIR_READ) begin
							// index zero holds the temperature word
							if (index_q == tsi_pkg::TEMP_INDEX) begin
								word_d = temp_value_word;
							end else begin
								word_d = reg_rd_data;
							end
							state_d = tsi_pkg::ST_RDATA;
							cnt_d   = 4'h0;
							if (index_q == tsi_pkg::TEMP_INDEX) begin
								shift_d = temp_value_word[15:8];
								oe_n_d  = temp_value_word[15];
							end else begin
								shift_d = reg_rd_data[15:8];
								oe_n_d  = reg_rd_data[15];
							end
							hi_done_d = 1'h1;
						end else begin
							state_d = tsi_pkg::ST_INDEX;
							oe_n_d  = 1'h1;
						end
					end
				end
				tsi_pkg::ST_INDEX_ACK, tsi_pkg::ST_WDATA_ACK: begin
					if (scl_fall) begin
						state_d = tsi_pkg::ST_WDATA;
						oe_n_d  = 1'h1;
					end
				end
				tsi_pkg::ST_RDATA: begin
					// ignore our own bits echoed by the capture path
					shift_d = shift_q;
					if (scl_fall) begin
						if (cnt_q == tsi_pkg::LAST_TX_BIT) begin
							state_d = tsi_pkg::ST_MACK;
							cnt_d   = 4'h0;
							oe_n_d  = 1'h1;
						end else begin
							cnt_d   = cnt_q + 4'h1;
							shift_d = {shift_q[6:0], 1'h0};
							oe_n_d  = shift_q[6];
						end
					end
				end
				tsi_pkg::ST_MACK: begin
					oe_n_d = 1'h1;
					if (bit_evt) begin
						nack_d = cap_bit;
						cnt_d  = tsi_pkg::ACK_SEEN;
					end
					if (scl_fall && cnt_q == tsi_pkg::ACK_SEEN) begin
						cnt_d = 4'h0;
						if (nack_q) begin
							state_d = tsi_pkg::ST_IDLE;
						end else if (hi_done_q) begin
							state_d   = tsi_pkg::ST_RDATA;
							shift_d   = word_q[7:0];
							oe_n_d    = word_q[7];
							hi_done_d = 1'h0;
						end else begin
							// word repeats while the master keeps acking
							state_d   = tsi_pkg::ST_RDATA;
							shift_d   = word_q[15:8];
							oe_n_d    = word_q[15];
							hi_done_d = 1'h1;
						end
					end
				end
				default: begin
					state_d = tsi_pkg::ST_IDLE;
					oe_n_d  = 1'h1;
				end
			endcase
		end
		busy_d = (state_d != tsi_pkg::ST_IDLE);
	end

	// protocol registers; the pointer survives every frame
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q   <= tsi_pkg::ST_IDLE;
			cnt_q     <= 4'h0;
			shift_q   <= 8'h00;
			rw_q      <= 1'h0;
			hi_done_q <= 1'h0;
			wr_hi_q   <= 8'h00;
			nack_q    <= 1'h0;
			word_q    <= 16'h0000;
			index_q   <= tsi_pkg::INDEX_RESET;
			reg_wr    <= '0;
			sda_oe_n  <= 1'h1;
			busy      <= 1'h0;
		end else begin
			state_q   <= state_d;
			cnt_q     <= cnt_d;
			shift_q   <= shift_d;
			rw_q      <= rw_d;
			hi_done_q <= hi_done_d;
			wr_hi_q   <= wr_hi_d;
			nack_q    <= nack_d;
			word_q    <= word_d;
			index_q   <= index_d;
			reg_wr    <= wr_d;
			sda_oe_n  <= oe_n_d;
			busy      <= busy_d;
		end
	end

	// open-drain: only ever pull low; clock line is never driven
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sda_o    <= 1'h0;
			scl_o    <= 1'h0;
			scl_oe_n <= 1'h1;
		end else begin
			sda_o    <= 1'h0;
			scl_o    <= 1'h0;
			scl_oe_n <= 1'h1;
		end
	end

	always_comb begin
		reg_index = index_q;
	end

endmodule : tsi_port

`default_nettype wire

//--- tb/tsi_port_assertions.sv
`timescale 1ns/1ns
`default_nettype none

module tsi_port_checker #(
	parameter int unsigned TIMEOUT_CYCLES = tsi_pkg::TIMEOUT_CYC
) (
	input wire logic             ref_clk,
	input wire logic             rst_n,
	input wire logic             scl_clk,
	input wire logic             sda_o,
	input wire logic             sda_oe_n,
	input wire logic             scl_o,
	input wire logic             scl_oe_n,
	input wire logic [7:0]       reg_index,
	input wire tsi_pkg::tsi_wr_s reg_wr,
	input wire logic             busy
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// clock-low run length; saturates so it never wraps
	logic [21:0] low_q;
	logic [21:0] low_d;
	always_comb begin
		low_d = low_q;
		if (scl_clk) begin
			low_d = 22'h000000;
		end else if (!low_q[21]) begin
			low_d = low_q + 22'h000001;
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			low_q <= 22'h000000;
		end else begin
			low_q <= low_d;
		end
	end

	property p_open_drain;
		scl_oe_n && (sda_oe_n || !sda_o);
	endproperty
	a_open_drain: assert property (p_open_drain)
		else $error("device drives a line high or drives the clock");
	property p_stable_high;
		scl_clk && $past(scl_clk) |-> $stable(sda_oe_n);
	endproperty
	a_stable_high: assert property (p_stable_high)
		else $error("data drive changed while clock high");
	property p_quiet_addr;
		$rose(busy) |-> sda_oe_n [*8];
	endproperty
	a_quiet_addr: assert property (p_quiet_addr)
		else $error("data driven during address byte");
	property p_ack_stands;
		$fell(sda_oe_n) |-> !sda_oe_n [*4];
	endproperty
	a_ack_stands: assert property (p_ack_stands)
		else $error("low drive too short");
	property p_idle_release;
		!busy && !$past(busy) |-> sda_oe_n;
	endproperty
	a_idle_release: assert property (p_idle_release)
		else $error("data driven while idle");
	property p_wr_pulse;
		reg_wr.valid |-> busy ##1 !reg_wr.valid;
	endproperty
	a_wr_pulse: assert property (p_wr_pulse)
		else $error("write pulse outside frame or too long");
	property p_index_kept;
		$changed(reg_index) |-> $past(busy);
	endproperty
	a_index_kept: assert property (p_index_kept)
		else $error("index changed outside a frame");
	property p_timeout;
		low_q >= TIMEOUT_CYCLES + 10 |-> !busy && sda_oe_n;
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("port not reset after long clock low");

	c_write: cover property (reg_wr.valid);
	c_drive: cover property ($fell(sda_oe_n));
	c_tout: cover property (low_q >= TIMEOUT_CYCLES + 10);
endmodule : tsi_port_checker

bind tsi_port tsi_port_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
	.ref_clk(ref_clk), .rst_n(rst_n), .scl_clk(scl_clk), .sda_o(sda_o),
	.sda_oe_n(sda_oe_n), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
	.reg_index(reg_index), .reg_wr(reg_wr), .busy(busy));

`default_nettype wire

//--- tb/tsi_bus_master.sv
`timescale 1ns/1ns
`default_nettype none

module tsi_bus_master (
	output var  logic scl,
	output var  logic sda_low,
	input  wire logic sda
);
	logic tick = 1'h0;
	int   lo   = 6; // low phase in ticks; raised to act as a slow master
	logic infr = 1'h0;

	// 32 ns timebase, offset so it is unrelated to the reference clock
	initial begin
		scl = 1'h1; // clock stands high between frames
		sda_low = 1'h0;
		#5;
		forever #16 tick = ~tick;
	end

	task automatic w(input int n);
		repeat (n) @(posedge tick);
	endtask : w

	// data moves mid-low only, so it is steady while the clock is high
	task automatic bit_io(input logic b, output logic s);
		scl = 1'h0;
		w(lo / 2);
		sda_low = ~b;
		w(lo - lo / 2);
		scl = 1'h1;
		w(4);
		s = sda;
	endtask : bit_io

	task automatic start();
		if (infr) begin
			scl = 1'h0;
			w(lo / 2);
			sda_low = 1'h0;
			w(lo - lo / 2);
			scl = 1'h1;
		end
		w(4);
		sda_low = 1'h1; // data falls with clock high
		w(4);
		infr = 1'h1;
	endtask : start

	task automatic stop();
		scl = 1'h0;
		w(lo / 2);
		sda_low = 1'h1;
		w(lo - lo / 2);
		scl = 1'h1;
		w(4);
		sda_low = 1'h0; // data rises with clock high
		w(4);
		infr = 1'h0;
	endtask : stop

	task automatic hold(input int n);
		scl = 1'h0;
		w(n);
	endtask : hold

	task automatic wr_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(b[i], s);
		bit_io(1'h1, ack); // released for the slave's acknowledge
	endtask : wr_byte

	task automatic rd_byte(input logic nack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'h1, s);
			b[i] = s;
		end
		bit_io(nack, s);
	endtask : rd_byte
endmodule : tsi_bus_master

`default_nettype wire

//--- tb/tsi_port_bench.sv
`timescale 1ns/1ns
`default_nettype none

module tsi_port_bench;
	localparam int unsigned TOUT = 200; // short stand-in for the 30 ms count
	logic               ref_clk  = 1'h0;
	logic               rst_n    = 1'h0;
	logic [1:0]         strap_hi = 2'h3;
	logic [1:0]         strap_lo = 2'h2;
	tsi_pkg::tsi_word_t temp_w   = 16'hEC00;
	tsi_pkg::tsi_word_t rd_w     = 16'hC3E1;
	logic [6:0]         slv      = 7'h46;
	logic               sda_w, scl_w, mst_scl, mst_low;
	logic               sda_o, sda_oe_n, scl_o, scl_oe_n, busy;
	logic [7:0]         reg_index;
	tsi_pkg::tsi_wr_s   reg_wr, wr_last;
	int                 miscompares = 0, tests_run = 0, wr_cnt = 0;

	initial begin
		forever #10 ref_clk = ~ref_clk;
	end
	// open-drain wires with pull-ups
	assign sda_w = !(mst_low || (!sda_oe_n && !sda_o));
	assign scl_w = mst_scl && (scl_oe_n || scl_o);

	tsi_port #(.TIMEOUT_CYCLES(TOUT)) uut (
		.ref_clk(ref_clk), .rst_n(rst_n), .scl_clk(scl_w), .sda_i(sda_w),
		.sda_o(sda_o), .sda_oe_n(sda_oe_n), .scl_o(scl_o),
		.scl_oe_n(scl_oe_n), .addr_strap_low(strap_lo),
		.addr_strap_high(strap_hi), .temp_value_word(temp_w),
		.reg_rd_data(rd_w), .reg_index(reg_index), .reg_wr(reg_wr),
		.busy(busy));
	tsi_bus_master mst (.scl(mst_scl), .sda_low(mst_low), .sda(sda_w));

	// keep the last register write for later comparison
	always @(posedge ref_clk) begin
		if (reg_wr.valid === 1'h1) begin
			wr_last <= reg_wr;
			wr_cnt <= wr_cnt + 1;
		end
	end

	task automatic chk(input string n, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic print_verdict();
		if (miscompares == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : print_verdict

	task automatic do_reset(input logic [1:0] h, input logic [1:0] l);
		@(posedge ref_clk);
		rst_n <= 1'h0;
		strap_hi <= h;
		strap_lo <= l;
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'h1;
		repeat (12) @(posedge ref_clk);
		chk("reg_index", 32'h0, reg_index);
		chk("busy", 32'h0, busy);
		chk("scl_oe_n", 32'h1, scl_oe_n);
	endtask : do_reset

	task automatic set_idx(input logic [7:0] idx, input logic more);
		logic a;
		mst.start();
		mst.wr_byte({slv, 1'h0}, a);
		chk("addr_ack", 32'h0, a);
		mst.wr_byte(idx, a);
		chk("idx_ack", 32'h0, a);
		if (!more) mst.stop();
	endtask : set_idx

	task automatic rd_word(input logic [6:0] adr, input logic [15:0] e);
		logic       a;
		logic [7:0] hi, lw;
		mst.start();
		mst.wr_byte({adr, 1'h1}, a);
		chk("rd_ack", 32'h0, a);
		mst.rd_byte(1'h0, hi);
		mst.rd_byte(1'h1, lw);
		mst.stop();
		chk("rd_word", e, {hi, lw});
	endtask : rd_word

	task automatic sc_write();
		logic a;
		int   n;
		n = wr_cnt;
		set_idx(8'h05, 1'h1);
		mst.wr_byte(8'hA5, a);
		chk("msb_ack", 32'h0, a);
		mst.wr_byte(8'h3C, a);
		chk("lsb_ack", 32'h0, a);
		mst.stop();
		repeat (4) @(posedge ref_clk);
		chk("wr_count", n + 1, wr_cnt);
		chk("wr_word", {1'h1, 8'h05, 16'hA53C}, wr_last);
		chk("index", 32'h05, reg_index);
		chk("busy", 32'h0, busy);
	endtask : sc_write

	task automatic sc_foreign();
		logic a;
		mst.start();
		mst.wr_byte(8'h90, a); // reset-default address, not ours
		chk("foreign_nack", 32'h1, a);
		mst.wr_byte(8'h00, a);
		chk("idle_nack", 32'h1, a);
		mst.stop();
	endtask : sc_foreign

	// address zero with the write bit is not ours and stays unanswered
	task automatic sc_gcall();
		logic a;
		mst.start();
		mst.wr_byte(8'h00, a);
		chk("gcall_nack", 32'h1, a);
		mst.stop();
	endtask : sc_gcall

	// a lone trailing byte must not produce a register write
	task automatic sc_odd();
		logic a;
		int   n;
		n = wr_cnt;
		set_idx(8'h05, 1'h1);
		mst.wr_byte(8'h5A, a);
		chk("odd_ack", 32'h0, a);
		mst.stop();
		repeat (4) @(posedge ref_clk);
		chk("odd_count", n, wr_cnt);
		chk("odd_busy", 32'h0, busy);
	endtask : sc_odd

	// master acks the low byte, so the same word starts over
	task automatic sc_rd_repeat();
		logic       a;
		logic [7:0] b0, b1, b2;
		mst.start();
		mst.wr_byte({slv, 1'h1}, a);
		chk("rep_ack", 32'h0, a);
		mst.rd_byte(1'h0, b0);
		mst.rd_byte(1'h0, b1);
		mst.rd_byte(1'h1, b2);
		mst.stop();
		chk("rep_word", 32'h0000EC00, {b0, b1});
		chk("rep_msb", 32'h000000EC, b2);
		chk("rep_busy", 32'h0, busy);
	endtask : sc_rd_repeat

	task automatic sc_read();
		set_idx(8'h07, 1'h1);
		rd_word(slv, 16'hC3E1);
		mst.lo = 20; // slow master
		rd_word(slv, 16'hC3E1);
		mst.lo = 6;
		rd_word(7'h00, 16'hC3E1);
		set_idx(8'h00, 1'h0);
		rd_word(slv, 16'hEC00);
	endtask : sc_read

	task automatic sc_timeout();
		logic a;
		mst.start();
		mst.wr_byte({slv, 1'h0}, a);
		mst.hold(140); // longer than the shortened count
		chk("tout_busy", 32'h0, busy);
		chk("tout_sda", 32'h1, sda_oe_n);
		mst.stop();
	endtask : sc_timeout

	// a hung frame ends the run rather than stalling it
	initial begin
		#2_000_000;
		miscompares++;
		print_verdict();
	end

	initial begin
		do_reset(2'h3, 2'h2);
		sc_write();
		sc_foreign();
		sc_gcall();
		sc_odd();
		do_reset(2'h1, 2'h3);
		slv = 7'h4B;
		sc_read();
		sc_rd_repeat();
		sc_timeout();
		print_verdict();
	end
endmodule : tsi_port_bench

`default_nettype wire
